// ---- bench/scsc_checker.sv ----
// assertions for the clock and sleep control block
// assumes only the top ports are visible; a bus shadow tracks the controls
`timescale 1ns/1ps
module scsc_checker (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // bus
    input wire scsc_pkg::scsc_ahb_req_t ahb_req,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // sources and controls
    input wire scsc_pkg::scsc_src_t src,
    input wire scsc_pkg::scsc_out_t ctl_out
);
    import scsc_pkg::*;
    // ----------------------------------------
    // bus shadow of the control bits
    // ----------------------------------------
    logic wr_r, keep_r, sup_r, xtal_r, sleep_r, quiet_r;
    logic [31:0] wa_r;
    wire quiet_now = sleep_r & sup_r & ~keep_r;
    wire sel32 = xtal_r ? src.eco32_tick : src.ilo32_tick;
    wire any_sys = src.imo_tick | src.ext_tick;
    wire any32 = src.ilo32_tick | src.eco32_tick;
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_r <= 1'b0;
            wa_r <= '0;
        end else begin
            wr_r <= ahb_req.hsel & ahb_req.htrans[1] & ahb_req.hready & ahb_req.hwrite;
            wa_r <= ahb_req.haddr;
        end
    end
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            {xtal_r, sup_r, keep_r, sleep_r, quiet_r} <= 5'h00;
        end else begin
            quiet_r <= quiet_now;
            if (wr_r && wa_r == ADDR_CLK_SRC) begin
                xtal_r <= ahb_req.hwdata[F_XTAL];
                sup_r <= ahb_req.hwdata[F_SUPPRESS];
                keep_r <= ahb_req.hwdata[F_KEEP_ON];
            end
            if (wr_r && wa_r == ADDR_CTRL) begin
                sleep_r <= ahb_req.hwdata[F_SLEEP_EN];
            end
        end
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge clk); endclocking
    default disable iff (!nrst);
    property p_sys_src; ctl_out.main_system_clock_en |-> $past(any_sys); endproperty
    a_sys_src: assert property (p_sys_src)
        else $error("system clock pulse without a source tick");
    property p_cp_gap; ctl_out.cp_clk_en |=> !ctl_out.cp_clk_en [*4]; endproperty
    a_cp_gap: assert property (p_cp_gap)
        else $error("pump pulses closer than five cycles");
    property p_wake_src; ctl_out.wake |-> $past(any32); endproperty
    a_wake_src: assert property (p_wake_src)
        else $error("wake without a 32k tick");
    property p_wake_one; ctl_out.wake |=> !ctl_out.wake [*8]; endproperty
    a_wake_one: assert property (p_wake_one)
        else $error("wake pulses too close");
    property p_keep; keep_r && $past(keep_r) |-> ctl_out.bandgap_on; endproperty
    a_keep: assert property (p_keep)
        else $error("bandgap off while keep-on set");
    property p_awake; !sleep_r && !$past(sleep_r) |-> ctl_out.bandgap_on; endproperty
    a_awake: assert property (p_awake)
        else $error("bandgap off while awake");
    property p_quiet; quiet_now && quiet_r |-> !ctl_out.bandgap_on; endproperty
    a_quiet: assert property (p_quiet)
        else $error("bandgap on while suppressed in sleep");
    property p_clk32; $past(nrst) |-> ctl_out.clk32_en == $past(sel32); endproperty
    a_clk32: assert property (p_clk32)
        else $error("32k enable not from selected source");
endmodule

bind scsc_top scsc_checker u_chk (.clk(clk), .nrst(nrst), .ahb_req(ahb_req), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .src(src), .ctl_out(ctl_out));

// ---- bench/tb_system_clock_and_sleep_control.sv ----
// self-checking bench for the clock and sleep control block
// assumes the checker binds itself; ticks come from a bench generator
`timescale 1ns/1ps
module tb_system_clock_and_sleep_control;
    import scsc_pkg::*;
    // ----------------------------------------
    // signals, design and monitors
    // ----------------------------------------
    logic clk = 1'b0;
    logic nrst = 1'b0;
    logic ph = 1'b0;
    logic rd_r = 1'b0;
    logic hreadyout, hresp;
    logic [31:0] hrdata;
    logic [3:0] tmode = 4'h0;
    logic [31:0] exp_q[$];
    scsc_ahb_req_t req = '0;
    scsc_ahb_req_t bus;
    scsc_src_t src = '0;
    scsc_out_t ctl_out;
    int fail_count = 0;
    int samples_checked = 0;
    always #10 clk = ~clk;
    always_comb begin
        bus = req;
        bus.hready = hreadyout;
    end
    scsc_top dut (.clk(clk), .nrst(nrst), .ahb_req(bus), .hrdata(hrdata),
        .hreadyout(hreadyout), .hresp(hresp), .src(src), .ctl_out(ctl_out));
    always @(posedge clk) begin
        ph <= ~ph;
        src.imo_tick <= tmode[0] & ph;
        src.ext_tick <= tmode[1] & ph;
        src.ilo32_tick <= tmode[2];
        src.eco32_tick <= tmode[3] & ph;
    end
    always @(posedge clk) begin
        if (rd_r && exp_q.size() > 0) begin
            samples_checked++;
            if (hrdata !== exp_q[0]) begin
                fail_count++;
                $display("mismatch at %0t: read %h expected %h", $time, hrdata, exp_q[0]);
            end
            void'(exp_q.pop_front());
        end
        rd_r <= nrst & bus.hsel & bus.htrans[1] & hreadyout & ~bus.hwrite;
    end
    // ----------------------------------------
    // tasks
    // ----------------------------------------
    task automatic stop_test();
        $display("checked %0d, mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic check(input int got, input int lo, input int hi, input string what);
        samples_checked++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("mismatch at %0t: %s gave %0d", $time, what, got);
        end
    endtask
    function automatic logic pick(input int sel);
        case (sel)
            0: return ctl_out.main_system_clock_en;
            1: return ctl_out.cp_clk_en;
            2: return ctl_out.bandgap_on;
            default: return ctl_out.wake;
        endcase
    endfunction
    task automatic wait_for(input int sel, input int bound, output int k);
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (pick(sel) !== 1'b1 && k < bound);
        if (pick(sel) !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: wait timeout", $time);
            stop_test();
        end
    endtask
    task automatic wait_ready();
        int k;
        k = 0;
        do begin
            @(posedge clk);
            k++;
        end while (hreadyout !== 1'b1 && k < 64);
        if (hreadyout !== 1'b1) begin
            fail_count++;
            $display("mismatch at %0t: bus timeout", $time);
            stop_test();
        end
    endtask
    task automatic count(input int sel, input int cyc, output int c);
        c = 0;
        repeat (cyc) begin
            @(posedge clk);
            c += int'(pick(sel) === 1'b1);
        end
    endtask
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        req <= '{1'b1, a, HTRANS_NONSEQ, w, 3'b010, req.hwdata, 1'b1};
        wait_ready();
        req <= '{1'b0, a, 2'b00, w, 3'b010, d, 1'b1};
        wait_ready();
        check(int'(hresp !== 1'b0), 0, 0, "response");
    endtask
    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        xfer(1'b1, a, d);
    endtask
    task automatic rd(input logic [31:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        xfer(1'b0, a, 32'h0000_0000);
    endtask
    // ----------------------------------------
    // main sequence
    // ----------------------------------------
    initial begin
        int divs[8] = '{8, 4, 2, 1, 16, 32, 128, 256};
        int slp[5] = '{64, 512, 4096, 32768, 128};
        int cps[4] = '{0, 128, 64, 0};
        int bgs[4] = '{8, 256, 0, 256};
        int n, m;
        logic [7:0] r;
        n = $urandom(31);
        repeat (2) @(posedge clk);
        nrst <= 1'b1;
        @(posedge clk);
        rd(ADDR_REG_IO, 32'(RST_REG_IO));
        rd(ADDR_CLK_SRC, 32'(RST_CLK_SRC));
        rd(ADDR_CTRL, 32'h0000_0000);
        rd(32'h0000_0100, 32'h0000_0000);
        rd(ADDR_STATUS, 32'h0000_000a);
        r = 8'($urandom()) & MASK_REG_IO;
        wr(ADDR_REG_IO, 32'(r));
        rd(ADDR_REG_IO, 32'(r));
        check(int'(ctl_out.reg_level !== r[F_REG_LEVEL_LO +: 3]), 0, 0, "level");
        r = 8'($urandom());
        wr(ADDR_CLK_SRC, 32'(r));
        rd(ADDR_CLK_SRC, 32'(r));
        $display("registers done");
        for (int i = 0; i < 9; i++) begin
            wr(ADDR_CTRL, 32'(i == 8));
            tmode <= (i == 8) ? 4'b0010 : 4'b0001;
            wr(ADDR_CLK_SRC, 32'(i % 8));
            wait_for(0, 2000, n);
            count(0, 1024, n);
            check(n, 512 / divs[i % 8], 512 / divs[i % 8], "divider");
        end
        wr(ADDR_CTRL, 32'h0000_0000);
        tmode <= 4'b0001;
        wr(ADDR_CLK_SRC, 32'h0000_0007);
        wait_for(0, 2000, n);
        wait_for(0, 2000, n);
        wr(ADDR_CLK_SRC, 32'h0000_0003);
        wait_for(0, 2000, n);
        check(n + 2, 511, 513, "switch boundary");
        $display("divider done");
        wr(ADDR_CLK_SRC, 32'h0000_0001);
        for (int p = 0; p < 4; p++) begin
            wr(ADDR_REG_IO, 32'(p));
            count(1, 64, n);
            count(1, 1024, n);
            check(n, cps[p], cps[p], "pump");
        end
        wr(ADDR_CLK_SRC, 32'h0000_0003);
        wr(ADDR_REG_IO, 32'h0000_0002);
        count(1, 64, n);
        count(1, 1024, n);
        check(n, 1, 1024 * 12 / 50, "pump ceiling");
        $display("pump done");
        for (int s = 0; s < 5; s++) begin
            wr(ADDR_CTRL, 32'h0000_0000);
            wr(ADDR_CLK_SRC, 32'((s % 4) << 3) | ((s == 4) ? 32'h0000_0080 : 32'h0000_0000));
            tmode <= (s == 4) ? 4'b1100 : 4'b0100;
            wr(ADDR_CTRL, 32'h0000_0002);
            wait_for(3, 40000, n);
            m = slp[s];
            check(n, m - 1, m + 3, "wake interval");
        end
        $display("sleep done");
        tmode <= 4'b0100;
        for (int b = 0; b < 4; b++) begin
            wr(ADDR_CTRL, 32'h0000_0000);
            wr(ADDR_CLK_SRC, 32'(b) << 5);
            wr(ADDR_CTRL, 32'h0000_0002);
            count(2, 40, n);
            count(2, 256, n);
            check(n, bgs[b], bgs[b], "bandgap");
        end
        wr(ADDR_CTRL, 32'h0000_0000);
        $display("bandgap done");
        stop_test();
    end
endmodule

// ---- hw/scsc_pkg.sv ----
// package for the system clock and sleep control block
// assumes a single 50 MHz clock and AHB-Lite register access
package scsc_pkg;
    // ------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------
    localparam int unsigned CLK_HZ = 50_000_000;
    localparam int unsigned CP_MAX_HZ = 12_000_000;
    localparam int unsigned CP_MIN_GAP_INT = (CLK_HZ + CP_MAX_HZ - 1) / CP_MAX_HZ;
    localparam logic [3:0] CP_MIN_GAP = CP_MIN_GAP_INT[3:0];
    // sleep periods in 32 kHz ticks, minus one
    localparam logic [15:0] SLP_LAST_00 = 16'h003f;
    localparam logic [15:0] SLP_LAST_01 = 16'h01ff;
    localparam logic [15:0] SLP_LAST_10 = 16'h0fff;
    localparam logic [15:0] SLP_LAST_11 = 16'h7fff;
    // ------------------------------------------------------------
    // register indices and byte addresses
    // ------------------------------------------------------------
    localparam logic [9:0] IDX_REG_IO = 10'h0de;
    localparam logic [9:0] IDX_CLK_SRC = 10'h0e0;
    localparam logic [9:0] IDX_CTRL = 10'h0f0;
    localparam logic [9:0] IDX_STATUS = 10'h0f1;
    localparam logic [31:0] ADDR_REG_IO = {20'h0_0000, IDX_REG_IO, 2'b00};
    localparam logic [31:0] ADDR_CLK_SRC = {20'h0_0000, IDX_CLK_SRC, 2'b00};
    localparam logic [31:0] ADDR_CTRL = {20'h0_0000, IDX_CTRL, 2'b00};
    localparam logic [31:0] ADDR_STATUS = {20'h0_0000, IDX_STATUS, 2'b00};
    // ------------------------------------------------------------
    // reset values and writable masks
    // ------------------------------------------------------------
    localparam logic [7:0] RST_REG_IO = 8'h00;
    localparam logic [7:0] RST_CLK_SRC = 8'h02;
    localparam logic [7:0] RST_CTRL = 8'h00;
    localparam logic [7:0] MASK_REG_IO = 8'h3b;
    localparam logic [7:0] MASK_CLK_SRC = 8'hff;
    localparam logic [7:0] MASK_CTRL = 8'h03;
    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int unsigned F_CP_SEL_LO = 0;
    localparam int unsigned F_REG_LEVEL_LO = 3;
    localparam int unsigned F_DIV_LO = 0;
    localparam int unsigned F_SLEEP_LO = 3;
    localparam int unsigned F_SUPPRESS = 6;
    localparam int unsigned F_KEEP_ON = 7 - 2;
    localparam int unsigned F_XTAL = 7;
    localparam int unsigned F_EXT_MODE = 0;
    localparam int unsigned F_SLEEP_EN = 1;
    // ------------------------------------------------------------
    // encodings and carriers
    // ------------------------------------------------------------
    localparam logic [1:0] CP_SEL_HALF = 2'b10;
    localparam logic [1:0] CP_SEL_FULL = 2'b01;
    localparam logic [1:0] HTRANS_NONSEQ = 2'b10;
    localparam int unsigned BUZZ_PERIOD = 32;

    typedef struct packed {
        logic hsel;
        logic [31:0] haddr;
        logic [1:0] htrans;
        logic hwrite;
        logic [2:0] hsize;
        logic [31:0] hwdata;
        logic hready;
    } scsc_ahb_req_t;

    typedef struct packed {
        logic imo_tick;
        logic ext_tick;
        logic ilo32_tick;
        logic eco32_tick;
    } scsc_src_t;

    typedef struct packed {
        logic main_system_clock_en;
        logic clk32_en;
        logic cp_clk_en;
        logic wake;
        logic bandgap_on;
        logic [2:0] reg_level;
    } scsc_out_t;
endpackage

// ---- hw/scsc_top.sv ----
// system clock divider, 32 kHz select, sleep timer, bandgap buzz and
// charge-pump clock control behind an AHB-Lite register slave
// assumes all source clocks arrive as one-cycle enables synchronous to clk
//
// Operation
// - divider codes 0..7 give /8,/4,/2,/1,/16,/32,/128,/256; reset code 010b
// - sleep codes 00..11 give 1.95 ms, 15.6 ms, 125 ms, 1 s at 32 kHz
// - bandgap keep-on set makes the suppress control ignored
// - suppress set, keep-on clear: bandgap stays off through sleep, no pulses
// - keep-on and suppress clear pulses bandgap while asleep; keep-on set holds it on
// - crystal select 0 routes internal 32 kHz, 1 routes external crystal
// - pump clock never exceeds 12 MHz, derived from system clock
//
// The AHB-Lite slave port was left to the implementer.
`timescale 1ns/1ps
module scsc_top (
    // clock and reset
    input wire logic clk,
    input wire logic nrst,
    // ahb-lite slave
    input wire scsc_pkg::scsc_ahb_req_t ahb_req,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // clock source ticks
    input wire scsc_pkg::scsc_src_t src,
    // clock enables and analog controls
    output scsc_pkg::scsc_out_t ctl_out
);
    import scsc_pkg::*;

    // ------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------
    function automatic logic [7:0] div_last(input logic [2:0] code);
        case (code)
            3'd0: div_last = 8'h07;
            3'd1: div_last = 8'h03;
            3'd2: div_last = 8'h01;
            3'd3: div_last = 8'h00;
            3'd4: div_last = 8'h0f;
            3'd5: div_last = 8'h1f;
            3'd6: div_last = 8'h7f;
            default: div_last = 8'hff;
        endcase
    endfunction

    function automatic logic [15:0] sleep_last(input logic [1:0] code);
        case (code)
            2'd0: sleep_last = SLP_LAST_00;
            2'd1: sleep_last = SLP_LAST_01;
            2'd2: sleep_last = SLP_LAST_10;
            default: sleep_last = SLP_LAST_11;
        endcase
    endfunction

    // register select from a byte address; 3'd4 when unmapped
    function automatic logic [2:0] reg_sel(input logic [31:0] addr);
        if (addr == ADDR_REG_IO) begin
            reg_sel = 3'd0;
        end else if (addr == ADDR_CLK_SRC) begin
            reg_sel = 3'd1;
        end else if (addr == ADDR_CTRL) begin
            reg_sel = 3'd2;
        end else if (addr == ADDR_STATUS) begin
            reg_sel = 3'd3;
        end else begin
            reg_sel = 3'd4;
        end
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0] reg_io_r;
    logic [7:0] reg_io_nxt;
    logic [7:0] clk_src_r;
    logic [7:0] clk_src_nxt;
    logic [7:0] ctrl_r;
    logic [7:0] ctrl_nxt;
    logic [31:0] hrdata_r;
    logic hreadyout_r;
    logic hresp_r;
    logic wr_pend_r;
    logic [31:0] wr_addr_r;
    logic addr_valid;
    logic [7:0] status;

    // core state
    logic [2:0] div_code_r;
    logic [7:0] div_cnt_r;
    logic main_system_clock_en_r;
    logic clk32_en_r;
    logic [15:0] slp_cnt_r;
    logic wake_r;
    logic [4:0] buzz_cnt_r;
    logic bg_on_r;
    logic cp_half_r;
    logic [3:0] cp_gap_r;
    logic cp_en_r;
    logic src_tick;
    logic tick32;
    logic keep_on;
    logic suppress;
    logic sleep_en;
    logic [1:0] cp_sel;
    logic cp_want;

    // ------------------------------------------------------------
    // ahb-lite slave
    // ------------------------------------------------------------
    assign addr_valid = ahb_req.hsel && ahb_req.htrans[1] && ahb_req.hready;

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 32'h0000_0000;
        end else begin
            wr_pend_r <= addr_valid && ahb_req.hwrite;
            if (addr_valid) begin
                wr_addr_r <= ahb_req.haddr;
            end
        end
    end

    // write data lands in the data phase
    always_comb begin
        reg_io_nxt = reg_io_r;
        clk_src_nxt = clk_src_r;
        ctrl_nxt = ctrl_r;
        if (wr_pend_r) begin
            if (reg_sel(wr_addr_r) == 3'd0) begin
                reg_io_nxt = ahb_req.hwdata[7:0] & MASK_REG_IO;
            end else if (reg_sel(wr_addr_r) == 3'd1) begin
                clk_src_nxt = ahb_req.hwdata[7:0] & MASK_CLK_SRC;
            end else if (reg_sel(wr_addr_r) == 3'd2) begin
                ctrl_nxt = ahb_req.hwdata[7:0] & MASK_CTRL;
            end
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            reg_io_r <= RST_REG_IO;
            clk_src_r <= RST_CLK_SRC;
            ctrl_r <= RST_CTRL;
        end else begin
            reg_io_r <= reg_io_nxt;
            clk_src_r <= clk_src_nxt;
            ctrl_r <= ctrl_nxt;
        end
    end

    assign status = {3'b000, clk_src_r[F_XTAL], bg_on_r, div_code_r};

    // read data built from next values so a read right after a write sees it
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            hrdata_r <= 32'h0000_0000;
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            hresp_r <= 1'b0;
            if (addr_valid && !ahb_req.hwrite) begin
                if (reg_sel(ahb_req.haddr) == 3'd0) begin
                    hrdata_r <= {24'h00_0000, reg_io_nxt};
                end else if (reg_sel(ahb_req.haddr) == 3'd1) begin
                    hrdata_r <= {24'h00_0000, clk_src_nxt};
                end else if (reg_sel(ahb_req.haddr) == 3'd2) begin
                    hrdata_r <= {24'h00_0000, ctrl_nxt};
                end else if (reg_sel(ahb_req.haddr) == 3'd3) begin
                    hrdata_r <= {24'h00_0000, status};
                end else begin
                    hrdata_r <= 32'h0000_0000;
                end
            end
        end
    end

    assign hrdata = hrdata_r;
    assign hreadyout = hreadyout_r;
    assign hresp = hresp_r;

    // ------------------------------------------------------------
    // field decode
    // ------------------------------------------------------------
    assign keep_on = clk_src_r[F_KEEP_ON];
    assign suppress = clk_src_r[F_SUPPRESS];
    assign sleep_en = ctrl_r[F_SLEEP_EN];
    assign cp_sel = reg_io_r[F_CP_SEL_LO +: 2];
    assign src_tick = ctrl_r[F_EXT_MODE] ? src.ext_tick : src.imo_tick;
    assign tick32 = clk_src_r[F_XTAL] ? src.eco32_tick : src.ilo32_tick;

    // ------------------------------------------------------------
    // system clock divider
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            div_code_r <= RST_CLK_SRC[F_DIV_LO +: 3];
            div_cnt_r <= 8'h00;
            main_system_clock_en_r <= 1'b0;
        end else begin
            main_system_clock_en_r <= 1'b0;
            if (src_tick) begin
                if (div_cnt_r >= div_last(div_code_r)) begin
                    div_cnt_r <= 8'h00;
                    main_system_clock_en_r <= 1'b1;
                    div_code_r <= clk_src_r[F_DIV_LO +: 3];
                end else begin
                    div_cnt_r <= div_cnt_r + 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // 32 kHz select and sleep timer
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            clk32_en_r <= 1'b0;
            slp_cnt_r <= 16'h0000;
            wake_r <= 1'b0;
        end else begin
            clk32_en_r <= tick32;
            wake_r <= 1'b0;
            if (!sleep_en) begin
                slp_cnt_r <= 16'h0000;
            end else if (tick32) begin
                if (slp_cnt_r >= sleep_last(clk_src_r[F_SLEEP_LO +: 2])) begin
                    slp_cnt_r <= 16'h0000;
                    wake_r <= 1'b1;
                end else begin
                    slp_cnt_r <= slp_cnt_r + 16'h0001;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // bandgap buzz during sleep
    // ------------------------------------------------------------
    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            buzz_cnt_r <= 5'h00;
        end else if (!sleep_en) begin
            buzz_cnt_r <= 5'h00;
        end else if (tick32) begin
            buzz_cnt_r <= (buzz_cnt_r == 5'(BUZZ_PERIOD - 1)) ? 5'h00 : buzz_cnt_r + 5'h01;
        end
    end

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            bg_on_r <= 1'b1;
        end else if (!sleep_en || keep_on) begin
            bg_on_r <= 1'b1;
        end else if (suppress) begin
            bg_on_r <= 1'b0;
        end else begin
            bg_on_r <= (buzz_cnt_r == 5'h00);
        end
    end

    // ------------------------------------------------------------
    // charge-pump clock
    // ------------------------------------------------------------
    assign cp_want = main_system_clock_en_r && ((cp_sel == CP_SEL_FULL) ||
                     ((cp_sel == CP_SEL_HALF) && cp_half_r));

    always_ff @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            cp_half_r <= 1'b0;
            cp_gap_r <= CP_MIN_GAP;
            cp_en_r <= 1'b0;
        end else begin
            cp_en_r <= 1'b0;
            if (main_system_clock_en_r) begin
                cp_half_r <= !cp_half_r;
            end
            // spacing guard keeps the pump at or below its top rate
            if (cp_want && (cp_gap_r >= CP_MIN_GAP)) begin
                cp_en_r <= 1'b1;
                cp_gap_r <= 4'h1;
            end else if (cp_gap_r < CP_MIN_GAP) begin
                cp_gap_r <= cp_gap_r + 4'h1;
            end
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign ctl_out.main_system_clock_en = main_system_clock_en_r;
    assign ctl_out.clk32_en = clk32_en_r;
    assign ctl_out.cp_clk_en = cp_en_r;
    assign ctl_out.wake = wake_r;
    assign ctl_out.bandgap_on = bg_on_r;
    assign ctl_out.reg_level = reg_io_r[F_REG_LEVEL_LO +: 3];
endmodule
